// file: inc/clm_pkg.sv
// Purpose: Shared constants for the channel lock monitor
// Assumes: 8-bit channel register file addressed by byte offset
// Notes: Register 0x34 holds the recheck count and the ready flag
package clm_pkg;
    // Register offsets
    localparam logic [7:0] LOCK_RECHECK_CTRL_ADDR = 8'h34;
    localparam logic [7:0] FREQ_TOL_ERR_CTRL_ADDR = 8'h35;
    localparam logic [7:0] FREQ_ERR_RESULT_HI_ADDR = 8'h3b;
    localparam logic [7:0] FREQ_ERR_RESULT_LO_ADDR = 8'h3c;
    // Field positions in lock_recheck_control
    localparam int READY_BIT = 7;
    localparam int LOW_POWER_DIS_BIT = 6;
    localparam int RECHECK_COUNT_HI_BIT = 5;
    localparam int RECHECK_COUNT_LO_BIT = 4;
    // Field positions in freq_tolerance_and_error_control
    localparam int TOL_SCALE_HI_BIT = 7;
    localparam int TOL_SCALE_LO_BIT = 6;
    localparam int CAPTURE_TRIG_BIT = 5;
    // Reset values
    localparam logic [1:0] RECHECK_COUNT_RESET = 2'h3;
    localparam logic [3:0] LOCK_RECHECK_RSVD_RESET = 4'hf;
    localparam logic [4:0] FREQ_TOL_RSVD_RESET = 5'h1f;
    localparam logic [1:0] TOL_SCALE_RESET = 2'h0;
    // Tolerance scale encodings
    localparam logic [1:0] SCALE_X1 = 2'h0;
    localparam logic [1:0] SCALE_X1_PLUS = 2'h1;
    localparam logic [1:0] SCALE_X2 = 2'h2;
    localparam logic [1:0] SCALE_X2_PLUS = 2'h3;
    // Lock supervision states
    typedef enum logic [1:0]
    {
        LOCK_IDLE = 2'b00,
        LOCK_HELD = 2'b01,
        LOCK_RECHECK = 2'b10
    } clm_lock_state_e;
endpackage : clm_pkg

// file: design/clm_tol_scale.sv
// Purpose: Scales the frequency delta tolerance by the two-bit scale field
// Assumes: Tolerance value is stable between checks
// Notes: Output is registered; one cycle of latency after a change
`timescale 1ns/1ps
module clm_tol_scale #(
    parameter int TOL_WIDTH = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [1:0] scale,
    input wire logic [TOL_WIDTH-1:0] tolIn,
    output logic [TOL_WIDTH+1:0] tolOut_ff
);
    logic [TOL_WIDTH+1:0] nxt_tolOut;
    logic [TOL_WIDTH+1:0] baseTol;
    logic [TOL_WIDTH+1:0] fracTol;

    // Bits 3:1 of the tolerance must exist for the addend
    if (TOL_WIDTH < 4)
    begin : g_tol_width_check
        $error("clm_tol_scale needs TOL_WIDTH of at least 4");
    end

    // Select multiplier and optional bits 3:1 addend
    always_comb
    begin
        baseTol = {2'h0, tolIn};
        fracTol = {{(TOL_WIDTH-1){1'b0}}, tolIn[3:1]};
        case (scale)
            clm_pkg::SCALE_X1: nxt_tolOut = baseTol;
            clm_pkg::SCALE_X1_PLUS: nxt_tolOut = baseTol + fracTol;
            clm_pkg::SCALE_X2: nxt_tolOut = baseTol << 1;
            clm_pkg::SCALE_X2_PLUS: nxt_tolOut = (baseTol << 1) + fracTol;
            default: nxt_tolOut = baseTol;
        endcase
    end

    // Registered so the lock comparator sees a glitch-free threshold
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            tolOut_ff <= '0;
        end
        else if (ce)
        begin
            tolOut_ff <= nxt_tolOut;
        end
    end
endmodule : clm_tol_scale

// file: design/clm_lock_monitor.sv
// Purpose: Per-channel lock supervision, tolerance scaling and frequency error capture
// Assumes: Check results and counter values are synchronous to clk
// Notes: Register port is the channel register access path; reads return one cycle later
//
// Summary of operation
// - After lock, every further check is still evaluated against the lock criteria.
// - A failed check is retried the programmed number of times before lock drops.
// - Two-bit recheck count sets extra checks, maximum three, resets to three.
// - A passing recheck keeps lock high and zeroes the failed-check counter.
// - Scale field gives tolerance x1, x1 plus bits 3:1, x2, or x2 plus.
// - Writing the trigger captures the error count; hardware clears the trigger after.
// - Result refreshes continuously; software may force a capture and read result registers.
// - Ready flag sets when a frequency error count is available for reading.
`timescale 1ns/1ps
module clm_lock_monitor #(
    parameter int TOL_WIDTH = 8,
    parameter int COUNT_WIDTH = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData_ff,
    input wire logic lockCheckValid,
    input wire logic lockCheckPass,
    input wire logic [TOL_WIDTH-1:0] ppmDelta,
    output logic [TOL_WIDTH+1:0] scaledTolerance,
    input wire logic ppmCountValid,
    input wire logic [COUNT_WIDTH-1:0] ppmCount,
    output logic [COUNT_WIDTH-1:0] freqErrorResult_ff,
    output logic lockDetect_ff,
    output logic lowPowerDisable,
    output logic freqErrorReady
);
    clm_pkg::clm_lock_state_e state_ff;
    clm_pkg::clm_lock_state_e nxt_state;
    logic [1:0] recheckCount_ff;
    logic [1:0] failCnt_ff;
    logic [1:0] nxt_failCnt;
    logic [3:0] lockRsvd_ff;
    logic lowPowerDis_ff;
    logic ready_ff;
    logic [1:0] tolScale_ff;
    logic captureTrig_ff;
    logic [4:0] tolRsvd_ff;
    logic wrLock;
    logic wrTol;
    logic capture;

    // Two result bytes must hold the count, no more and no less
    if (COUNT_WIDTH < 9 || COUNT_WIDTH > 16)
    begin : g_count_width_check
        $error("clm_lock_monitor needs COUNT_WIDTH between 9 and 16");
    end

    assign wrLock = regWrEn && (regAddr == clm_pkg::LOCK_RECHECK_CTRL_ADDR);
    assign wrTol = regWrEn && (regAddr == clm_pkg::FREQ_TOL_ERR_CTRL_ADDR);
    // Forced capture and the continuous refresh both load the same current count
    assign capture = captureTrig_ff || ppmCountValid;
    assign lowPowerDisable = lowPowerDis_ff;
    assign freqErrorReady = ready_ff;

    // Tolerance scaling lives in its own module so it can be reused per lane
    clm_tol_scale #(
        .TOL_WIDTH(TOL_WIDTH)
    ) u_clm_tol_scale (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .scale(tolScale_ff),
        .tolIn(ppmDelta),
        .tolOut_ff(scaledTolerance)
    );

    // Lock supervision next state; checks never stop once locked
    always_comb
    begin
        nxt_state = state_ff;
        nxt_failCnt = failCnt_ff;
        if (lockCheckValid)
        begin
            case (state_ff)
                clm_pkg::LOCK_IDLE:
                begin
                    if (lockCheckPass)
                    begin
                        nxt_state = clm_pkg::LOCK_HELD;
                    end
                    nxt_failCnt = 2'h0;
                end
                clm_pkg::LOCK_HELD:
                begin
                    // A single failure only drops lock when no rechecks are programmed
                    if (!lockCheckPass)
                    begin
                        nxt_state = (recheckCount_ff == 2'h0) ? clm_pkg::LOCK_IDLE
                                                              : clm_pkg::LOCK_RECHECK;
                    end
                    nxt_failCnt = 2'h0;
                end
                clm_pkg::LOCK_RECHECK:
                begin
                    if (lockCheckPass)
                    begin
                        nxt_state = clm_pkg::LOCK_HELD;
                        nxt_failCnt = 2'h0;
                    end
                    else if ({1'b0, failCnt_ff} + 3'h1 >= {1'b0, recheckCount_ff})
                    begin
                        nxt_state = clm_pkg::LOCK_IDLE;
                        nxt_failCnt = 2'h0;
                    end
                    else
                    begin
                        nxt_failCnt = failCnt_ff + 2'h1;
                    end
                end
                default:
                begin
                    nxt_state = clm_pkg::LOCK_IDLE;
                    nxt_failCnt = 2'h0;
                end
            endcase
        end
    end

    // Lock state, failed-check counter and indication
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_ff <= clm_pkg::LOCK_IDLE;
            failCnt_ff <= 2'h0;
            lockDetect_ff <= 1'b0;
        end
        else if (ce)
        begin
            state_ff <= nxt_state;
            failCnt_ff <= nxt_failCnt;
            lockDetect_ff <= (nxt_state != clm_pkg::LOCK_IDLE);
        end
    end

    // Lock recheck control register; ready flag set wins over a software clear
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            recheckCount_ff <= clm_pkg::RECHECK_COUNT_RESET;
            lockRsvd_ff <= clm_pkg::LOCK_RECHECK_RSVD_RESET;
            lowPowerDis_ff <= 1'b0;
            ready_ff <= 1'b0;
        end
        else if (ce)
        begin
            if (wrLock)
            begin
                recheckCount_ff <= regWrData[clm_pkg::RECHECK_COUNT_HI_BIT:clm_pkg::RECHECK_COUNT_LO_BIT];
                lockRsvd_ff <= regWrData[3:0];
                lowPowerDis_ff <= regWrData[clm_pkg::LOW_POWER_DIS_BIT];
                ready_ff <= regWrData[clm_pkg::READY_BIT];
            end
            if (capture)
            begin
                ready_ff <= 1'b1;
            end
        end
    end

    // Tolerance and capture control; the trigger self-clears after one capture
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            tolScale_ff <= clm_pkg::TOL_SCALE_RESET;
            captureTrig_ff <= 1'b0;
            tolRsvd_ff <= clm_pkg::FREQ_TOL_RSVD_RESET;
        end
        else if (ce)
        begin
            if (captureTrig_ff)
            begin
                captureTrig_ff <= 1'b0;
            end
            if (wrTol)
            begin
                tolScale_ff <= regWrData[clm_pkg::TOL_SCALE_HI_BIT:clm_pkg::TOL_SCALE_LO_BIT];
                tolRsvd_ff <= regWrData[4:0];
                // Writing zero leaves a pending capture alone
                if (regWrData[clm_pkg::CAPTURE_TRIG_BIT])
                begin
                    captureTrig_ff <= 1'b1;
                end
            end
        end
    end

    // Frequency error result, refreshed continuously or on a forced capture
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            freqErrorResult_ff <= '0;
        end
        else if (ce && capture)
        begin
            freqErrorResult_ff <= ppmCount;
        end
    end

    // Registered read port; unmapped offsets read zero
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            regRdData_ff <= 8'h00;
        end
        else if (ce && regRdEn)
        begin
            case (regAddr)
                clm_pkg::LOCK_RECHECK_CTRL_ADDR:
                    regRdData_ff <= {ready_ff, lowPowerDis_ff, recheckCount_ff, lockRsvd_ff};
                clm_pkg::FREQ_TOL_ERR_CTRL_ADDR:
                    regRdData_ff <= {tolScale_ff, captureTrig_ff, tolRsvd_ff};
                clm_pkg::FREQ_ERR_RESULT_HI_ADDR:
                    regRdData_ff <= 8'(freqErrorResult_ff >> 8);
                clm_pkg::FREQ_ERR_RESULT_LO_ADDR:
                    regRdData_ff <= freqErrorResult_ff[7:0];
                default:
                    regRdData_ff <= 8'h00;
            endcase
        end
    end

    property p_keep_checking;
        @(posedge clk) disable iff (reset)
        (ce && state_ff == clm_pkg::LOCK_HELD && lockCheckValid && !lockCheckPass)
            |=> (state_ff != clm_pkg::LOCK_HELD);
    endproperty
    a_keep_checking: assert property (p_keep_checking) else $error("Locked failure ignored");

    property p_no_drop_first;
        @(posedge clk) disable iff (reset)
        (ce && state_ff == clm_pkg::LOCK_HELD && lockCheckValid && !lockCheckPass && recheckCount_ff != 2'h0)
            |=> lockDetect_ff;
    endproperty
    a_no_drop_first: assert property (p_no_drop_first) else $error("Lock dropped on first failure");

    property p_final_fail;
        @(posedge clk) disable iff (reset)
        (ce && state_ff == clm_pkg::LOCK_RECHECK && lockCheckValid && !lockCheckPass
            && failCnt_ff + 2'h1 == recheckCount_ff) |=> !lockDetect_ff;
    endproperty
    a_final_fail: assert property (p_final_fail) else $error("Lock kept after last recheck");

    property p_count_reset;
        @(posedge clk) reset |=> (recheckCount_ff == 2'h3 && !captureTrig_ff && !ready_ff && !lockDetect_ff);
    endproperty
    a_count_reset: assert property (p_count_reset) else $error("Wrong reset values");

    property p_regain;
        @(posedge clk) disable iff (reset)
        (ce && state_ff == clm_pkg::LOCK_RECHECK && lockCheckValid && lockCheckPass)
            |=> (lockDetect_ff && failCnt_ff == 2'h0);
    endproperty
    a_regain: assert property (p_regain) else $error("Regained lock not held");

    property p_scale_x2;
        @(posedge clk) disable iff (reset)
        (ce && tolScale_ff == clm_pkg::SCALE_X2)
            |=> (scaledTolerance == {1'b0, $past(ppmDelta), 1'b0});
    endproperty
    a_scale_x2: assert property (p_scale_x2) else $error("Tolerance not doubled");

    property p_trig_capture;
        @(posedge clk) disable iff (reset)
        (ce && captureTrig_ff) |=> (!captureTrig_ff || $past(wrTol)) && freqErrorResult_ff == $past(ppmCount);
    endproperty
    a_trig_capture: assert property (p_trig_capture) else $error("Forced capture failed");

    property p_continuous;
        @(posedge clk) disable iff (reset)
        (ce && ppmCountValid) |=> (freqErrorResult_ff == $past(ppmCount)) ##0 ready_ff;
    endproperty
    a_continuous: assert property (p_continuous) else $error("Result not refreshed");
endmodule : clm_lock_monitor

// file: verif/clm_lock_monitor_tb.sv
// Purpose: Self-checking bench for the channel lock monitor
// Assumes: Register reads answer one cycle after the strobe; lock output settles one cycle after a check
// Notes: All stimulus lands by non-blocking assignment on the rising edge
`timescale 1ns/1ps
module clm_lock_monitor_tb;
    logic clk;
    logic reset;
    logic ce;
    logic regWrEn;
    logic regRdEn;
    logic [7:0] regAddr;
    logic [7:0] regWrData;
    logic [7:0] regRdData_ff;
    logic lockCheckValid;
    logic lockCheckPass;
    logic [7:0] ppmDelta;
    logic [9:0] scaledTolerance;
    logic ppmCountValid;
    logic [15:0] ppmCount;
    logic [15:0] freqErrorResult_ff;
    logic lockDetect_ff;
    logic lowPowerDisable;
    logic freqErrorReady;
    int failCount;
    int samplesChecked;

    clm_lock_monitor #(.TOL_WIDTH(8), .COUNT_WIDTH(16)) u_clm_lock_monitor (
        .clk(clk), .reset(reset), .ce(ce), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData_ff(regRdData_ff),
        .lockCheckValid(lockCheckValid), .lockCheckPass(lockCheckPass), .ppmDelta(ppmDelta),
        .scaledTolerance(scaledTolerance), .ppmCountValid(ppmCountValid), .ppmCount(ppmCount),
        .freqErrorResult_ff(freqErrorResult_ff), .lockDetect_ff(lockDetect_ff),
        .lowPowerDisable(lowPowerDisable), .freqErrorReady(freqErrorReady)
    );

    // 100 ns clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Counts, prints the verdict and stops the run
    task automatic finishTest();
        $display("Checks made: %0d, mismatches: %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finishTest

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            failCount++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask : wr

    // Read data is registered, so compare one edge after the taking edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRdEn <= 1'b0;
        @(posedge clk);
        #1;
        chk({8'h00, regRdData_ff}, {8'h00, exp});
    endtask : rd

    // One check result, then compare the lock level once it has settled
    task automatic lockCheck(input logic pass, input logic expLock);
        @(posedge clk);
        lockCheckValid <= 1'b1;
        lockCheckPass <= pass;
        @(posedge clk);
        lockCheckValid <= 1'b0;
        lockCheckPass <= ~pass;
        @(posedge clk);
        #1;
        chk({15'h0, lockDetect_ff}, {15'h0, expLock});
    endtask : lockCheck

    function automatic logic [9:0] scaleExp(input logic [1:0] s, input logic [7:0] d);
        logic [9:0] base;
        base = s[1] ? {1'b0, d, 1'b0} : {2'b00, d};
        return base + (s[0] ? {7'h00, d[3:1]} : 10'h000);
    endfunction : scaleExp

    // Ready may lag the capture by a cycle; the wait is bounded
    task automatic waitReady();
        int n;
        n = 0;
        while (freqErrorReady !== 1'b1 && n < 8)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({15'h0, freqErrorReady}, 16'h0001);
        // A flag that never rose is a hang; go straight to the verdict
        if (freqErrorReady !== 1'b1)
        begin
            finishTest();
        end
    endtask : waitReady

    // Watchdog so a stuck design still reaches the verdict
    initial
    begin
        repeat (20000) @(posedge clk);
        failCount++;
        finishTest();
    end

    initial
    begin
        failCount = 0;
        samplesChecked = 0;
        reset = 1'b1;
        ce = 1'b1;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        lockCheckValid = 1'b0;
        lockCheckPass = 1'b0;
        ppmDelta = 8'hb6;
        ppmCountValid = 1'b0;
        ppmCount = 16'h0000;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        // Reset values, unmapped place
        rd(clm_pkg::LOCK_RECHECK_CTRL_ADDR, 8'h3f);
        rd(clm_pkg::FREQ_TOL_ERR_CTRL_ADDR, 8'h1f);
        rd(8'h36, 8'h00);
        chk({15'h0, lockDetect_ff}, 16'h0000);
        // Every scale code against tolerance 0xb6, whose bits 3:1 are nonzero, so the addend matters
        for (int s = 0; s < 4; s++)
        begin
            wr(clm_pkg::FREQ_TOL_ERR_CTRL_ADDR, {s[1:0], 6'h1f});
            repeat (2) @(posedge clk);
            #1;
            chk({6'h00, scaledTolerance}, {6'h00, scaleExp(s[1:0], ppmDelta)});
        end
        wr(clm_pkg::FREQ_TOL_ERR_CTRL_ADDR, 8'h1f);
        // Each recheck count: n failures hold lock, a pass resets, n+1 failures drop it
        for (int n = 3; n >= 0; n--)
        begin
            wr(clm_pkg::LOCK_RECHECK_CTRL_ADDR, {2'b00, n[1:0], 4'hf});
            lockCheck(1'b1, 1'b1);
            for (int k = 0; k < n; k++)
                lockCheck(1'b0, 1'b1);
            lockCheck(1'b1, 1'b1);
            for (int k = 0; k < n; k++)
                lockCheck(1'b0, 1'b1);
            lockCheck(1'b0, 1'b0);
        end
        // Low-power bit and count read back
        wr(clm_pkg::LOCK_RECHECK_CTRL_ADDR, 8'h7f);
        rd(clm_pkg::LOCK_RECHECK_CTRL_ADDR, 8'h7f);
        chk({15'h0, lowPowerDisable}, 16'h0001);
        // Continuous refresh path
        @(posedge clk);
        ppmCount <= 16'h1234;
        ppmCountValid <= 1'b1;
        @(posedge clk);
        ppmCountValid <= 1'b0;
        ppmCount <= 16'h5a5a;
        waitReady();
        chk(freqErrorResult_ff, 16'h1234);
        rd(clm_pkg::FREQ_ERR_RESULT_HI_ADDR, 8'h12);
        rd(clm_pkg::FREQ_ERR_RESULT_LO_ADDR, 8'h34);
        rd(clm_pkg::LOCK_RECHECK_CTRL_ADDR, 8'hff);
        wr(clm_pkg::LOCK_RECHECK_CTRL_ADDR, 8'h3f);
        rd(clm_pkg::LOCK_RECHECK_CTRL_ADDR, 8'h3f);
        // Software trigger captures a count that never pulsed valid
        @(posedge clk);
        ppmCount <= 16'hbeef;
        wr(clm_pkg::FREQ_TOL_ERR_CTRL_ADDR, 8'h3f);
        waitReady();
        chk(freqErrorResult_ff, 16'hbeef);
        rd(clm_pkg::FREQ_TOL_ERR_CTRL_ADDR, 8'h1f);
        rd(clm_pkg::FREQ_ERR_RESULT_HI_ADDR, 8'hbe);
        rd(clm_pkg::FREQ_ERR_RESULT_LO_ADDR, 8'hef);
        // Software clear of ready meets a fresh count in one cycle: the set wins
        @(posedge clk);
        regWrEn <= 1'b1;
        regAddr <= clm_pkg::LOCK_RECHECK_CTRL_ADDR;
        regWrData <= 8'h3f;
        ppmCount <= 16'h0c3d;
        ppmCountValid <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
        ppmCountValid <= 1'b0;
        rd(clm_pkg::LOCK_RECHECK_CTRL_ADDR, 8'hbf);
        rd(clm_pkg::FREQ_ERR_RESULT_HI_ADDR, 8'h0c);
        rd(clm_pkg::FREQ_ERR_RESULT_LO_ADDR, 8'h3d);
        // Clock enable low makes a write vanish
        @(posedge clk);
        ce <= 1'b0;
        wr(clm_pkg::FREQ_TOL_ERR_CTRL_ADDR, 8'hdf);
        @(posedge clk);
        ce <= 1'b1;
        rd(clm_pkg::FREQ_TOL_ERR_CTRL_ADDR, 8'h1f);
        finishTest();
    end
endmodule : clm_lock_monitor_tb
